// ==== design/prio_regs_pkg.sv ====
// Package: register map, field layout and bus types for the priority register bank
package prio_regs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int NUM_REGS = 9;
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] BASE_OFFSET = 16'h10D0;
  localparam logic [ADDR_W-1:0] REG_STRIDE = 16'h0010;
  localparam logic [3:0] SUB_BASE = 4'h0;
  localparam logic [3:0] SUB_CLEAR = 4'h4;
  localparam logic [3:0] SUB_SET = 4'h8;
  localparam logic [3:0] SUB_TOGGLE = 4'hC;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_4 = 16'h10D0;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_5 = 16'h10E0;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_6 = 16'h10F0;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_7 = 16'h1100;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_8 = 16'h1110;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_9 = 16'h1120;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_10 = 16'h1130;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_11 = 16'h1140;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_12 = 16'h1150;
  // Index of the register holding DMA channels four to seven
  localparam int DMA_HIGH_IDX = 6;

  // ****************************************
  // Field layout
  // ****************************************
  localparam logic [31:0] IMPL_MASK = 32'h1F1F_1F1F;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  localparam int UPPER_PRIO_LSB = 10;
  localparam int UPPER_SUB_LSB = 8;
  localparam int LOWER_PRIO_LSB = 2;
  localparam int LOWER_SUB_LSB = 0;
  localparam int HALF_W = 16;
  localparam logic [2:0] PRIO_DISABLED = 3'h0;

  // ****************************************
  // Bus types
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] prio;
    logic [1:0] sub;
  } src_field_t;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_CLEAR = 2'h1,
    OP_SET = 2'h2,
    OP_TOGGLE = 2'h3
  } wr_op_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

endpackage : prio_regs_pkg

// ==== design/interrupt_priority_regs.sv ====
// Interrupt priority register bank with clear, set and toggle aliases on AXI4-Lite
// ****************************************
// Summary of operation
// - Three-bit priority one to seven in binary; zero disables the source.
// - Two-bit sub-priority levels zero to three held as plain binary.
// - Upper source of each half: priority bits 12-10, sub-priority bits 9-8.
// - Lower source of each half: priority bits 4-2, sub-priority bits 1-0.
// - Bits 7-5 and other unassigned bits are unimplemented and read zero.
// - Each register also answers at +0x4 clear, +0x8 set, +0xC toggle.
// - All priority and sub-priority fields reset to zero, sources disabled.
// - Reduced variant: DMA channel four to seven fields unimplemented, read zero.
// ****************************************
`timescale 1ns/100ps
module interrupt_priority_regs #(
  parameter int NUM_REGS = prio_regs_pkg::NUM_REGS,
  parameter bit REDUCED_DMA = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire prio_regs_pkg::axil_req_t bus_req,
  output prio_regs_pkg::axil_rsp_t bus_rsp,
  output prio_regs_pkg::src_field_t [4*NUM_REGS-1:0] source_field,
  output logic [4*NUM_REGS-1:0] source_enabled
);

  // ****************************************
  // Field geometry
  // ****************************************
  localparam int BYTES = 4;
  localparam int BYTE_W = 8;
  localparam int PRIO_W = 3;
  localparam int SUB_W = 2;
  localparam int SRC_PER_REG = 4;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (NUM_REGS < 1 || NUM_REGS > prio_regs_pkg::NUM_REGS) begin : g_bad_count
    $error("NUM_REGS out of range");
  end

  if (prio_regs_pkg::UPPER_PRIO_LSB + PRIO_W > prio_regs_pkg::HALF_W) begin : g_bad_upper
    $error("upper field overflows half");
  end

  if (2*prio_regs_pkg::HALF_W != BYTES*BYTE_W) begin : g_bad_half
    $error("halves do not fill a word");
  end

  if (REDUCED_DMA && NUM_REGS <= prio_regs_pkg::DMA_HIGH_IDX) begin : g_bad_reduced
    $error("reduced variant needs the DMA register");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NUM_REGS-1:0][31:0] regs;
    logic aw_held;
    logic [prio_regs_pkg::ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [NUM_REGS-1:0][31:0] impl_mask;
  logic [NUM_REGS-1:0][31:0] reg_view;
  logic [31:0] strb_mask;

  // Per-register writable mask
  genvar gi;
  for (gi = 0; gi < NUM_REGS; gi++) begin : g_mask
    if (REDUCED_DMA && gi == prio_regs_pkg::DMA_HIGH_IDX) begin : g_red
      assign impl_mask[gi] = 32'h0000_0000;
    end else begin : g_full
      assign impl_mask[gi] = prio_regs_pkg::IMPL_MASK;
    end
  end

  // ****************************************
  // Byte strobe mask
  // ****************************************
  genvar gb;
  for (gb = 0; gb < BYTES; gb++) begin : g_strb
    assign strb_mask[BYTE_W*gb +: BYTE_W] = {BYTE_W{state_reg.w_strb[gb]}};
  end

  // ****************************************
  // Implemented view of each register
  // ****************************************
  genvar gv;
  for (gv = 0; gv < NUM_REGS; gv++) begin : g_view
    assign reg_view[gv] = state_reg.regs[gv] & impl_mask[gv];
  end

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic decode(input logic [prio_regs_pkg::ADDR_W-1:0] addr, output int idx,
      output prio_regs_pkg::wr_op_t op);
    logic [prio_regs_pkg::ADDR_W-1:0] rel;
    logic ok;

    rel = addr - prio_regs_pkg::BASE_OFFSET;
    idx = int'(rel[prio_regs_pkg::ADDR_W-1:4]);

    // Below the bank, past the last register or not word aligned
    ok = (addr >= prio_regs_pkg::BASE_OFFSET) && (idx < NUM_REGS) && (addr[1:0] == 2'h0);

    // Sub-offset picks the plain, clear, set or toggle view
    case (rel[3:0])
      prio_regs_pkg::SUB_BASE: op = prio_regs_pkg::OP_WRITE;
      prio_regs_pkg::SUB_CLEAR: op = prio_regs_pkg::OP_CLEAR;
      prio_regs_pkg::SUB_SET: op = prio_regs_pkg::OP_SET;
      prio_regs_pkg::SUB_TOGGLE: op = prio_regs_pkg::OP_TOGGLE;
      default: begin
        op = prio_regs_pkg::OP_WRITE;
        ok = 1'b0;
      end
    endcase

    return ok;
  endfunction : decode

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    int widx;
    int ridx;
    prio_regs_pkg::wr_op_t wop;
    prio_regs_pkg::wr_op_t rop;
    logic wok;
    logic rok;
    logic [31:0] bmask;
    logic [31:0] cur;
    logic [31:0] upd;

    widx = 0;
    ridx = 0;
    wop = prio_regs_pkg::OP_WRITE;
    rop = prio_regs_pkg::OP_WRITE;
    wok = 1'b0;
    rok = 1'b0;
    bmask = 32'h0000_0000;
    cur = 32'h0000_0000;
    upd = 32'h0000_0000;
    state_next = state_reg;

    // ****************************************
    // Write address and data capture
    // ****************************************
    // Either order; each half waits for the other
    if (bus_req.awvalid && !state_reg.aw_held) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = bus_req.awaddr;
    end

    if (bus_req.wvalid && !state_reg.w_held) begin
      state_next.w_held = 1'b1;
      state_next.w_data = bus_req.wdata;
      state_next.w_strb = bus_req.wstrb;
    end

    // ****************************************
    // Write response
    // ****************************************
    if (state_reg.bvalid && bus_req.bready) begin
      state_next.bvalid = 1'b0;
    end

    // ****************************************
    // Write execution
    // ****************************************
    // Only once both halves are held and the response slot is free
    if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
      wok = decode(state_reg.aw_addr, widx, wop);
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = wok ? prio_regs_pkg::RESP_OKAY : prio_regs_pkg::RESP_SLVERR;

      if (wok) begin
        bmask = strb_mask & impl_mask[widx];
        cur = state_reg.regs[widx];

        case (wop)
          prio_regs_pkg::OP_CLEAR: upd = cur & ~state_reg.w_data;
          prio_regs_pkg::OP_SET: upd = cur | state_reg.w_data;
          prio_regs_pkg::OP_TOGGLE: upd = cur ^ state_reg.w_data;
          default: upd = state_reg.w_data;
        endcase

        // Only strobed, implemented bits take the new value
        state_next.regs[widx] = (cur & ~bmask) | (upd & bmask);
      end
    end

    // ****************************************
    // Read channel
    // ****************************************
    if (state_reg.rvalid && bus_req.rready) begin
      state_next.rvalid = 1'b0;
    end

    rok = decode(bus_req.araddr, ridx, rop);

    // Alias addresses read back the register itself
    if (bus_req.arvalid && !state_reg.rvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = rok ? prio_regs_pkg::RESP_OKAY : prio_regs_pkg::RESP_SLVERR;
      state_next.rdata = rok ? reg_view[ridx] : 32'h0000_0000;
    end

    // ****************************************
    // Synchronous reset
    // ****************************************
    if (!aresetn) begin
      state_next = '0;
      for (int r = 0; r < NUM_REGS; r++) begin
        state_next.regs[r] = prio_regs_pkg::RESET_VALUE;
      end
    end
  end

  always_ff @(posedge aclk) begin
    state_reg <= state_next;
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Write side: ready while the half is not held
  always_comb begin
    bus_rsp.awready = !state_reg.aw_held;
    bus_rsp.wready = !state_reg.w_held;
    bus_rsp.bvalid = state_reg.bvalid;
    bus_rsp.bresp = state_reg.bresp;
  end

  // Read side: one read in flight at a time
  always_comb begin
    bus_rsp.arready = !state_reg.rvalid;
    bus_rsp.rvalid = state_reg.rvalid;
    bus_rsp.rdata = state_reg.rdata;
    bus_rsp.rresp = state_reg.rresp;
  end

  // ****************************************
  // Field fan-out, two sources per half
  // ****************************************
  genvar gr;
  for (gr = 0; gr < NUM_REGS; gr++) begin : g_src
    for (genvar h = 0; h < 2; h++) begin : g_half
      localparam int LO = SRC_PER_REG*gr + 2*h;
      localparam int HI = LO + 1;
      localparam int B = prio_regs_pkg::HALF_W*h;
      localparam int LP = B + prio_regs_pkg::LOWER_PRIO_LSB;
      localparam int LS = B + prio_regs_pkg::LOWER_SUB_LSB;
      localparam int UP = B + prio_regs_pkg::UPPER_PRIO_LSB;
      localparam int US = B + prio_regs_pkg::UPPER_SUB_LSB;
      logic [31:0] v;

      assign v = reg_view[gr];

      // Lower source of the half
      assign source_field[LO].prio = v[LP +: PRIO_W];
      assign source_field[LO].sub = v[LS +: SUB_W];
      assign source_enabled[LO] = v[LP +: PRIO_W] != prio_regs_pkg::PRIO_DISABLED;

      // Upper source of the half
      assign source_field[HI].prio = v[UP +: PRIO_W];
      assign source_field[HI].sub = v[US +: SUB_W];
      assign source_enabled[HI] = v[UP +: PRIO_W] != prio_regs_pkg::PRIO_DISABLED;
    end
  end

endmodule : interrupt_priority_regs

// ==== verif/prio_regs_sva.sv ====
// Checker for the priority register bank
`timescale 1ns/100ps
module prio_regs_sva #(
  parameter int NUM_REGS = 9,
  parameter bit REDUCED_DMA = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire prio_regs_pkg::axil_req_t bus_req,
  input wire prio_regs_pkg::axil_rsp_t bus_rsp,
  input wire prio_regs_pkg::src_field_t [4*NUM_REGS-1:0] source_field,
  input wire logic [4*NUM_REGS-1:0] source_enabled
);
  // ****
  // Checks
  // ****
  logic [4*NUM_REGS-1:0] en_calc;
  always_comb begin
    for (int i = 0; i < 4*NUM_REGS; i++) begin
      en_calc[i] = source_field[i].prio != prio_regs_pkg::PRIO_DISABLED;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_enable_code: assert property (source_enabled == en_calc)
    else $error("enable flag disagrees with priority");
  a_unimpl_zero: assert property (bus_rsp.rvalid |-> (bus_rsp.rdata & ~prio_regs_pkg::IMPL_MASK) == 32'h0)
    else $error("unimplemented bits read nonzero");
  a_reset_clear: assert property ($rose(aresetn) |-> source_enabled == '0)
    else $error("sources enabled after reset");
  a_dma_blank: assert property (!REDUCED_DMA || source_field[27:24] == '0)
    else $error("reduced channel fields nonzero");
  a_field_hold: assert property ($changed(source_field) |-> $rose(bus_rsp.bvalid))
    else $error("fields changed without write");
  a_bresp_hold: assert property (bus_rsp.bvalid && !bus_req.bready |=> bus_rsp.bvalid && $stable(bus_rsp.bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (bus_rsp.rvalid && !bus_req.rready |=> bus_rsp.rvalid && $stable(bus_rsp.rdata))
    else $error("read data dropped");
  a_read_answer: assert property (bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid)
    else $error("read answer late");
  a_write_answer: assert property (bus_req.awvalid && bus_rsp.awready && bus_req.wvalid && bus_rsp.wready
    |-> ##2 bus_rsp.bvalid)
    else $error("write answer late");
  c_slverr: cover property (bus_rsp.bvalid && bus_rsp.bresp == prio_regs_pkg::RESP_SLVERR);
  c_read: cover property (bus_rsp.rvalid && bus_rsp.rdata != 32'h0);
  c_enabled: cover property (&source_enabled[3:0]);
endmodule : prio_regs_sva
bind interrupt_priority_regs prio_regs_sva #(.NUM_REGS(NUM_REGS), .REDUCED_DMA(REDUCED_DMA)) u_prio_regs_sva (
  .aclk(aclk), .aresetn(aresetn), .bus_req(bus_req), .bus_rsp(bus_rsp),
  .source_field(source_field), .source_enabled(source_enabled));

// ==== verif/interrupt_priority_regs_tb_top.sv ====
// Self-checking bench for the priority register bank
`timescale 1ns/100ps
module interrupt_priority_regs_tb_top;
  // ****
  // Bench
  // ****
  localparam logic [15:0] BAD [4] = '{16'h10CC, 16'h1160, 16'h10D2, 16'h1151};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  prio_regs_pkg::axil_req_t bus_req = '0;
  prio_regs_pkg::axil_rsp_t bus_rsp;
  prio_regs_pkg::src_field_t [35:0] source_field;
  logic [35:0] source_enabled;
  logic [31:0] model [9] = '{default: 32'h0};
  logic [33:0] exp_q [$];
  logic [15:0] a;
  int num_errors = 0;
  int comparisons = 0;
  always #10 aclk = ~aclk;
  interrupt_priority_regs #(.NUM_REGS(9), .REDUCED_DMA(1'b1)) u_interrupt_priority_regs (
    .aclk(aclk), .aresetn(aresetn), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .source_field(source_field), .source_enabled(source_enabled));
  task automatic check(input logic [179:0] got, input logic [179:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  function automatic logic [1:0] resp_of(input logic [15:0] x);
    return (x >= 16'h10D0 && x <= 16'h115C && x[1:0] == 2'h0) ? 2'h0 : 2'h2;
  endfunction : resp_of
  task automatic wr(input logic [15:0] x, input logic [31:0] d);
    int n;
    int r;
    logic [31:0] m;
    n = 0;
    r = int'((x - 16'h10D0) >> 4);
    @(posedge aclk);
    exp_q.push_back({resp_of(x), 32'h0});
    if (resp_of(x) == 2'h0 && r != 6) begin
      m = model[r];
      case (x[3:2])
        2'h0: m = d;
        2'h1: m = m & ~d;
        2'h2: m = m | d;
        default: m = m ^ d;
      endcase
      model[r] = m & prio_regs_pkg::IMPL_MASK;
    end
    bus_req.awaddr <= x;
    bus_req.wdata <= d;
    bus_req.awvalid <= 1'b1;
    bus_req.wvalid <= 1'b1;
    bus_req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (bus_rsp.awready) bus_req.awvalid <= 1'b0;
      if (bus_rsp.wready) bus_req.wvalid <= 1'b0;
    end while (!bus_rsp.bvalid && n < 50);
    bus_req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] x);
    int n;
    int r;
    n = 0;
    r = int'((x - 16'h10D0) >> 4);
    @(posedge aclk);
    exp_q.push_back(resp_of(x) == 2'h0 ? {2'h0, model[r]} : {2'h2, 32'h0});
    bus_req.araddr <= x;
    bus_req.arvalid <= 1'b1;
    bus_req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (bus_rsp.arready) bus_req.arvalid <= 1'b0;
    end while (!bus_rsp.rvalid && n < 50);
    bus_req.rready <= 1'b0;
  endtask : rd
  task automatic fields();
    logic [179:0] f;
    logic [35:0] e;
    for (int i = 0; i < 36; i++) begin
      f[5*i +: 5] = model[i/4][8*(i%4) +: 5];
      e[i] = f[5*i+2 +: 3] != 3'h0;
    end
    check(source_field, f, "fields");
    check(source_enabled, e, "enables");
  endtask : fields
  always @(posedge aclk) begin
    if (bus_rsp.bvalid && bus_req.bready) check({bus_rsp.bresp, 32'h0}, exp_q.pop_front(), "bresp");
    if (bus_rsp.rvalid && bus_req.rready) check({bus_rsp.rresp, bus_rsp.rdata}, exp_q.pop_front(), "read");
  end
  task automatic results();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial begin
    #400000;
    num_errors++;
    results();
  end
  initial begin
    void'($urandom(32'hC87DFB89));
    bus_req.wstrb <= 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int r = 0; r < 9; r++) rd(16'h10D0 + 16'(r) * 16'h10);
    for (int p = 0; p < 8; p++) begin
      wr(16'h10D0, {4{3'h0, 3'(p), 2'(p)}});
      fields();
    end
    for (int k = 0; k < 72; k++) begin
      a = 16'h10D0 + 16'(k % 9) * 16'h10 + 16'(k / 9 % 4) * 16'h4;
      wr(a, $urandom());
      rd(a ^ (16'($urandom()) & 16'h000C));
      fields();
    end
    foreach (BAD[i]) begin
      wr(BAD[i], 32'hFFFF_FFFF);
      rd(BAD[i]);
    end
    fields();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (model[i]) model[i] = 32'h0;
    for (int r = 0; r < 9; r++) rd(16'h10DC + 16'(r) * 16'h10);
    fields();
    repeat (2) @(posedge aclk);
    check(exp_q.size(), 0, "pending");
    results();
  end
endmodule : interrupt_priority_regs_tb_top
